/* core/dis_pkg.sv */
`default_nettype none
package dis_pkg;

  // Number of driver input lines on the driver connector
  localparam int NUM_IN = 7;

  // Function assigned to a driver input line
  typedef logic [2:0] dis_func_t;
  localparam dis_func_t FUNC_GENERAL = 3'h0;
  localparam dis_func_t FUNC_ALARM   = 3'h1;
  localparam dis_func_t FUNC_END     = 3'h2;
  localparam dis_func_t FUNC_TIMING  = 3'h3;
  localparam dis_func_t FUNC_TZERO   = 3'h4;
  localparam dis_func_t FUNC_MOVE    = 3'h5;
  localparam dis_func_t FUNC_LIMIT   = 3'h6;
  localparam dis_func_t FUNC_READY   = 3'h7;

  // Bit positions in the system input status word
  localparam int SYS_BIT_ALARM  = 0;
  localparam int SYS_BIT_END    = 1;
  localparam int SYS_BIT_TIMING = 2;
  localparam int SYS_BIT_TZERO  = 3;
  localparam int SYS_BIT_MOVE   = 4;
  localparam int SYS_BIT_LIMIT  = 5;
  localparam int SYS_BIT_READY  = 6;

  // End source encodings and the value used when nothing was saved
  localparam logic END_SRC_INTERNAL = 1'b0;
  localparam logic END_SRC_DRIVER   = 1'b1;
  localparam logic END_SRC_FACTORY  = 1'b0;

  // Reset values
  localparam logic [6:0] STATUS_RST = 7'h00;
  localparam logic [6:0] SYNC_RST   = 7'h00;

  typedef enum logic [1:0] {
    END_ACTION_SELECT_AREA  = 2'b00,
    END_ACTION_SELECT_PULSE = 2'b01,
    END_ACTION_SELECT_BOTH  = 2'b10,
    END_ACTION_SELECT_ANY   = 2'b11
  } dis_end_action_select_e;

  typedef enum logic {
    BOOT_LOAD = 1'b0,
    BOOT_RUN  = 1'b1
  } dis_boot_e;

  typedef struct packed {
    logic [6:0] system;
    logic [6:0] general;
  } dis_status_s;

endpackage
`default_nettype wire

/* core/dis_top.sv */
`timescale 1ns/1ps
`default_nettype none
module dis_top (
  input  wire  logic                       clk,
  input  wire  logic                       reset_n,
  input  wire  logic [6:0]                 drv_in,
  input  wire  dis_pkg::dis_func_t [6:0]   in_func,
  input  wire  logic                       in_end_area,
  input  wire  logic                       pulse_gen_done,
  input  wire  dis_pkg::dis_end_action_select_e       end_action_select,
  input  wire  logic                       seq_mode,
  input  wire  logic                       cmd_end_sel_wr,
  input  wire  logic                       cmd_end_sel_data,
  input  wire  logic                       save_parameters,
  input  wire  logic                       nv_end_sel,
  input  wire  logic                       nv_end_sel_valid,
  input  wire  logic                       monitor_enable,
  output var   dis_pkg::dis_status_s       status,
  output logic                             system_end_status,
  output logic                             internal_end,
  output logic                             end_source_active,
  output logic                             end_source_pending,
  output logic                             end_sel_wr_refused,
  output logic                             nv_save_strobe,
  output logic                             nv_save_data,
  output logic                             monitor_update
);

  // ************************************************************
  // Decoding helpers
  // ************************************************************

  // Weight of each assigned system signal; unassigned inputs add nothing
  function automatic logic [6:0] pack_system(
    input logic [6:0]               lines,
    input dis_pkg::dis_func_t [6:0] funcs
  );
    logic [6:0] word;
    word = dis_pkg::STATUS_RST;
    for (int i = 0; i < dis_pkg::NUM_IN; i++) begin
      if (lines[i]) begin
        case (funcs[i])
          dis_pkg::FUNC_ALARM:  word[dis_pkg::SYS_BIT_ALARM]  = 1'b1;
          dis_pkg::FUNC_END:    word[dis_pkg::SYS_BIT_END]    = 1'b1;
          dis_pkg::FUNC_TIMING: word[dis_pkg::SYS_BIT_TIMING] = 1'b1;
          dis_pkg::FUNC_TZERO:  word[dis_pkg::SYS_BIT_TZERO]  = 1'b1;
          dis_pkg::FUNC_MOVE:   word[dis_pkg::SYS_BIT_MOVE]   = 1'b1;
          dis_pkg::FUNC_LIMIT:  word[dis_pkg::SYS_BIT_LIMIT]  = 1'b1;
          dis_pkg::FUNC_READY:  word[dis_pkg::SYS_BIT_READY]  = 1'b1;
          default:              word = word;
        endcase
      end
    end
    return word;
  endfunction

  // Input k lands on bit k; an assigned input is masked out
  function automatic logic [6:0] pack_general(
    input logic [6:0]               lines,
    input dis_pkg::dis_func_t [6:0] funcs
  );
    logic [6:0] word;
    word = dis_pkg::STATUS_RST;
    for (int i = 0; i < dis_pkg::NUM_IN; i++) begin
      word[i] = lines[i] && (funcs[i] == dis_pkg::FUNC_GENERAL);
    end
    return word;
  endfunction

  // ************************************************************
  // Input synchroniser
  // ************************************************************

  logic [6:0] sync_meta;
  logic [6:0] sync_line;
  logic [6:0] next_sync_meta;
  logic [6:0] next_sync_line;

  always_comb begin
    next_sync_meta = drv_in;
    next_sync_line = sync_meta;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_meta <= dis_pkg::SYNC_RST;
      sync_line <= dis_pkg::SYNC_RST;
    end else begin
      sync_meta <= next_sync_meta;
      sync_line <= next_sync_line;
    end
  end

  // ************************************************************
  // Status words and monitor
  // ************************************************************

  dis_pkg::dis_status_s next_status;
  logic                 next_monitor_update;

  always_comb begin
    // Both words follow the synchronised lines and in_func only; there is no write path
    next_status.system  = pack_system(sync_line, in_func);
    next_status.general = pack_general(sync_line, in_func);
    // Change pulses feed a live display, suppressed inside stored sequences
    next_monitor_update = monitor_enable && !seq_mode
                          && (next_status != status);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status.system  <= dis_pkg::STATUS_RST;
      status.general <= dis_pkg::STATUS_RST;
      monitor_update <= 1'b0;
    end else begin
      status         <= next_status;
      monitor_update <= next_monitor_update;
    end
  end

  // ************************************************************
  // End source selection and system end status
  // ************************************************************

  dis_pkg::dis_boot_e boot_state;
  dis_pkg::dis_boot_e next_boot_state;
  logic               next_end_source_active;
  logic               next_end_source_pending;
  logic               next_end_sel_wr_refused;
  logic               next_nv_save_strobe;
  logic               next_nv_save_data;
  logic               next_internal_end;
  logic               next_system_end_status;
  logic               boot_value;

  always_comb begin
    next_boot_state         = boot_state;
    next_end_source_active  = end_source_active;
    next_end_source_pending = end_source_pending;
    next_end_sel_wr_refused = 1'b0;
    next_nv_save_strobe     = 1'b0;
    next_nv_save_data       = nv_save_data;
    boot_value = nv_end_sel_valid ? nv_end_sel : dis_pkg::END_SRC_FACTORY;

    case (boot_state)
      dis_pkg::BOOT_LOAD: begin
        // Saved value is caught on the first edge after reset release
        next_end_source_active  = boot_value;
        next_end_source_pending = boot_value;
        next_boot_state         = dis_pkg::BOOT_RUN;
      end
      dis_pkg::BOOT_RUN: begin
        // The working selection never moves here; only a reset reloads it
        if (cmd_end_sel_wr) begin
          if (seq_mode) begin
            next_end_sel_wr_refused = 1'b1;
          end else begin
            next_end_source_pending = cmd_end_sel_data;
          end
        end
        if (save_parameters) begin
          next_nv_save_strobe = 1'b1;
          next_nv_save_data   = next_end_source_pending;
        end
      end
      default: begin
        next_boot_state = dis_pkg::BOOT_LOAD;
      end
    endcase

    case (end_action_select)
      dis_pkg::END_ACTION_SELECT_AREA:  next_internal_end = in_end_area;
      dis_pkg::END_ACTION_SELECT_PULSE: next_internal_end = pulse_gen_done;
      dis_pkg::END_ACTION_SELECT_BOTH:  next_internal_end = in_end_area
                                                 && pulse_gen_done;
      default:               next_internal_end = in_end_area
                                                 || pulse_gen_done;
    endcase

    // Driver end line can chatter at low speed; internal is the safer pick
    if (end_source_active == dis_pkg::END_SRC_DRIVER) begin
      next_system_end_status = next_status.system[dis_pkg::SYS_BIT_END];
    end else begin
      next_system_end_status = next_internal_end;
    end
    // Held low until the saved selection has been loaded
    if (boot_state == dis_pkg::BOOT_LOAD) begin
      next_system_end_status = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      boot_state         <= dis_pkg::BOOT_LOAD;
      end_source_active  <= dis_pkg::END_SRC_FACTORY;
      end_source_pending <= dis_pkg::END_SRC_FACTORY;
      end_sel_wr_refused <= 1'b0;
      nv_save_strobe     <= 1'b0;
      nv_save_data       <= dis_pkg::END_SRC_FACTORY;
      internal_end       <= 1'b0;
      system_end_status  <= 1'b0;
    end else begin
      boot_state         <= next_boot_state;
      end_source_active  <= next_end_source_active;
      end_source_pending <= next_end_source_pending;
      end_sel_wr_refused <= next_end_sel_wr_refused;
      nv_save_strobe     <= next_nv_save_strobe;
      nv_save_data       <= next_nv_save_data;
      internal_end       <= next_internal_end;
      system_end_status  <= next_system_end_status;
    end
  end

endmodule
`default_nettype wire

/* test/dis_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module dis_chk (
  input wire logic                     clk,
  input wire logic                     reset_n,
  input wire dis_pkg::dis_func_t [6:0] in_func,
  input wire logic                     in_end_area,
  input wire logic                     pulse_gen_done,
  input wire dis_pkg::dis_end_action_select_e     end_action_select,
  input wire logic                     seq_mode,
  input wire logic                     cmd_end_sel_wr,
  input wire logic                     cmd_end_sel_data,
  input wire dis_pkg::dis_status_s     status,
  input wire logic                     system_end_status,
  input wire logic                     internal_end,
  input wire logic                     end_source_active,
  input wire logic                     end_source_pending,
  input wire logic                     end_sel_wr_refused
);
  logic [6:0] assigned;
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      assigned[i] = (in_func[i] != dis_pkg::FUNC_GENERAL);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Three cycles skip the boot cycle, where the end status is forced low
  sequence int_held; !end_source_active [*3]; endsequence
  sequence drv_held; end_source_active [*2]; endsequence
  area_end_a: assert property (end_action_select == dis_pkg::END_ACTION_SELECT_AREA
    |=> internal_end == $past(in_end_area)) else $error("area end wrong");
  both_end_a: assert property (end_action_select == dis_pkg::END_ACTION_SELECT_BOTH
    |=> internal_end == $past(in_end_area & pulse_gen_done)) else $error("and");
  pulse_end_a: assert property (end_action_select == dis_pkg::END_ACTION_SELECT_PULSE
    |=> internal_end == $past(pulse_gen_done)) else $error("pulse end wrong");
  any_end_a: assert property (end_action_select == dis_pkg::END_ACTION_SELECT_ANY
    |=> internal_end == $past(in_end_area | pulse_gen_done)) else $error("or");
  int_follow_a: assert property (int_held
    |-> system_end_status == internal_end) else $error("internal end lost");
  drv_follow_a: assert property (drv_held |-> system_end_status ==
    status.system[dis_pkg::SYS_BIT_END]) else $error("driver end lost");
  wr_refuse_a: assert property (seq_mode && cmd_end_sel_wr
    |=> end_sel_wr_refused && $stable(end_source_pending)) else $error("ref");
  wr_take_a: assert property (!seq_mode && cmd_end_sel_wr |=>
    end_source_pending == $past(cmd_end_sel_data)) else $error("write lost");
  active_hold_a: assert property (reset_n [*2]
    |=> $stable(end_source_active)) else $error("active changed");
  assigned_zero_a: assert property ($stable(in_func) [*4]
    |-> (status.general & assigned) == 7'h00) else $error("assigned shown");
endmodule
bind dis_top dis_chk u_dis_chk (.clk(clk), .reset_n(reset_n),
  .in_func(in_func), .in_end_area(in_end_area),
  .pulse_gen_done(pulse_gen_done), .end_action_select(end_action_select),
  .seq_mode(seq_mode), .cmd_end_sel_wr(cmd_end_sel_wr),
  .cmd_end_sel_data(cmd_end_sel_data), .status(status),
  .system_end_status(system_end_status), .internal_end(internal_end),
  .end_source_active(end_source_active),
  .end_source_pending(end_source_pending),
  .end_sel_wr_refused(end_sel_wr_refused));
`default_nettype wire

/* test/dis_drv_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dis_drv_model (
  input  wire logic       clk,
  input  wire logic [6:0] level,
  output var  logic [6:0] lines
);
  // Lines move only after a clock edge and never chatter
  initial lines = 7'h00;
  always @(posedge clk) lines <= level;
endmodule
`default_nettype wire

/* test/dis_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module dis_top_test;
  logic                     clk = 1'b0;
  logic                     reset_n = 1'b0;
  logic [6:0]               level = 7'h00;
  logic [6:0]               drv_in;
  dis_pkg::dis_func_t [6:0] in_func = '0;
  logic                     area = 1'b0;
  logic                     pdone = 1'b0;
  dis_pkg::dis_end_action_select_e     act = dis_pkg::END_ACTION_SELECT_AREA;
  logic                     seq = 1'b0;
  logic                     wr = 1'b0;
  logic                     wr_data = 1'b0;
  logic                     save = 1'b0;
  logic                     nv_sel = 1'b0;
  logic                     nv_valid = 1'b0;
  dis_pkg::dis_status_s     status;
  logic                     sys_end, int_end, active, pending, refused;
  logic                     nv_strobe, nv_data;
  logic                     mon_en = 1'b1;
  logic                     mon;
  int                       errors = 0;
  int                       n_tests = 0;
  always #2 clk = ~clk;
  dis_drv_model u_dis_drv_model (.clk(clk), .level(level), .lines(drv_in));
  dis_top u_dis_top (.clk(clk), .reset_n(reset_n), .drv_in(drv_in),
    .in_func(in_func), .in_end_area(area), .pulse_gen_done(pdone),
    .end_action_select(act), .seq_mode(seq), .cmd_end_sel_wr(wr),
    .cmd_end_sel_data(wr_data), .save_parameters(save),
    .nv_end_sel(nv_sel), .nv_end_sel_valid(nv_valid),
    .monitor_enable(mon_en), .status(status), .system_end_status(sys_end),
    .internal_end(int_end), .end_source_active(active),
    .end_source_pending(pending), .end_sel_wr_refused(refused),
    .nv_save_strobe(nv_strobe), .nv_save_data(nv_data),
    .monitor_update(mon));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk_w(input logic [6:0] got, input logic [6:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic drive(input logic [6:0] v);
    @(posedge clk);
    level <= v;
    tick(5);
  endtask
  task automatic t_general;
    for (int i = 0; i < 7; i++) begin
      drive(7'h01 << i);
      chk_w(status.general, 7'h01 << i);
      chk_w(status.system, 7'h00);
    end
    drive(7'h7F);
    chk_w(status.general, 7'h7F);
    $display("general word test done");
  endtask
  task automatic t_system;
    int pos [7] = '{dis_pkg::SYS_BIT_ALARM, dis_pkg::SYS_BIT_END,
      dis_pkg::SYS_BIT_TIMING, dis_pkg::SYS_BIT_TZERO, dis_pkg::SYS_BIT_MOVE,
      dis_pkg::SYS_BIT_LIMIT, dis_pkg::SYS_BIT_READY};
    @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      in_func[i] <= dis_pkg::dis_func_t'(i + 1);
    end
    drive(7'h7F);
    chk_w(status.general, 7'h00);
    chk_w(status.system, 7'h7F);
    for (int i = 0; i < 7; i++) begin
      drive(7'h01 << i);
      chk_w(status.system, 7'h01 << pos[i]);
    end
    $display("system word test done");
  endtask
  task automatic t_end;
    logic e;
    for (int m = 0; m < 4; m++) begin
      for (int c = 0; c < 4; c++) begin
        @(posedge clk);
        act <= dis_pkg::dis_end_action_select_e'(m[1:0]);
        area <= c[0];
        pdone <= c[1];
        tick(2);
        e = (m == 0) ? c[0] : (m == 1) ? c[1] : (m == 2) ? &c[1:0] : |c[1:0];
        chk_w({6'h00, int_end}, {6'h00, e});
        chk_w({6'h00, sys_end}, {6'h00, e});
      end
    end
    $display("end source test done");
  endtask
  task automatic t_select;
    @(posedge clk);
    seq <= 1'b1;
    wr <= 1'b1;
    wr_data <= 1'b1;
    area <= 1'b0;
    pdone <= 1'b0;
    @(posedge clk);
    seq <= 1'b0;
    #1;
    chk_w({6'h00, refused}, 7'h01);
    chk_w({6'h00, pending}, 7'h00);
    @(posedge clk);
    wr <= 1'b0;
    save <= 1'b1;
    #1;
    chk_w({6'h00, pending}, 7'h01);
    @(posedge clk);
    save <= 1'b0;
    nv_sel <= 1'b1;
    nv_valid <= 1'b1;
    #1;
    chk_w({5'h00, nv_strobe, nv_data}, 7'h03);
    chk_w({6'h00, active}, 7'h00);
    @(posedge clk);
    reset_n <= 1'b0;
    @(posedge clk);
    reset_n <= 1'b1;
    tick(3);
    chk_w({6'h00, active}, 7'h01);
    drive(7'h02);
    chk_w({6'h00, sys_end}, 7'h01);
    drive(7'h00);
    chk_w({6'h00, sys_end}, 7'h00);
    $display("selection test done");
  endtask
  task automatic t_monitor;
    drive(7'h00);
    @(posedge clk);
    level <= 7'h04;
    tick(4);
    chk_w({6'h00, mon}, 7'h01);
    tick(1);
    chk_w({6'h00, mon}, 7'h00);
    @(posedge clk);
    seq <= 1'b1;
    level <= 7'h00;
    tick(4);
    chk_w({6'h00, mon}, 7'h00);
    @(posedge clk);
    seq <= 1'b0;
    mon_en <= 1'b0;
    level <= 7'h04;
    tick(4);
    chk_w({6'h00, mon}, 7'h00);
    @(posedge clk);
    mon_en <= 1'b1;
    $display("monitor test done");
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    tick(3);
    t_general;
    t_system;
    t_end;
    t_select;
    t_monitor;
    test_done;
  end
  initial begin
    #20000;
    errors++;
    test_done;
  end
endmodule
`default_nettype wire
